// ==== rtl/mcr_bank.sv ====
// misc register bank: rx overrun watermark, chip id, led mode,
// indirect statistics counter access and power event control.
// assumes the serial front end delivers one-cycle rd/wr strobes
// with a byte address and byte enables, synchronous to clk.
//
// Function
// - 12-bit rx overrun watermark in dwords, reset 0x040, bits 15-12 reserved
// - id register returns fixed family, chip and revision fields, bit0 reserved
// - led mode bit 9 swaps indicator meanings between speed/link-act and act/link
// - every write to indirect command register starts an indirect command
// - read enable set and table select 11: read the counter then clear it; otherwise no operation
// - five-bit indirect address picks one of 32 statistics counters
// - data low register presents counter bits 15-0
// - data high register presents counter bits 31-16
// - delay enable holds power event output until clocks are ready
// - delay setting only counts while auto wake-up enable is set
// - offsets b6-bf, c2-c5, ca-cf are reserved with no function
// - auto wake-up returns to normal power once energy persists long enough
`timescale 1ns/1ns
module mcr_bank
   import mcr_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [1:0]  reg_be,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   output logic             reg_rvalid,
   // statistics events, one pulse per counter
   input  wire logic [31:0] stat_inc,
   // link status for the indicators
   input  wire logic        link_up,
   input  wire logic        speed100,
   input  wire logic        activity,
   output logic             indicator_first,
   output logic             indicator_second,
   // power management
   input  wire logic        wake_event,
   input  wire logic        clocks_ready,
   input  wire logic        energy_mode,
   input  wire logic        low_power,
   input  wire logic        energy_persisted,
   output logic             power_event_output,
   output logic             wake_to_normal,
   // settings used by the queue manager
   output logic [11:0]      watermark_config_field
);

   // -----------------------------------------------------------------
   // storage and decode
   // -----------------------------------------------------------------
   logic [11:0] rx_overrun_watermark;
   logic        cid_rsv;
   logic [15:0] global_chip_control;
   logic [15:0] indirect_access_command;
   logic [15:0] indirect_data_low_word;
   logic [15:0] indirect_data_high_word;
   logic [2:0]  power_event_control;   // {bit14, bit13, bit7}
   logic [31:0] stat_cnt [NUM_CNT];
   logic [7:0]  word_addr;
   logic [15:0] cid_word;
   logic [15:0] next_iac;
   logic        cmd_go;
   logic [4:0]  cmd_addr;
   logic [31:0] sel_val;
   logic        dly_active;
   logic        led_mode_select;

   assign word_addr = {reg_addr[7:1], 1'b0};
   assign cid_word  = {ID_FAM, ID_CHIP, ID_REV, cid_rsv};
   assign watermark_config_field = rx_overrun_watermark;
   assign led_mode_select = global_chip_control[LED_SEL_BIT];

   // byte-lane merge for partial writes
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] nw,
                                         input logic [1:0]  be);
      merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
   endfunction

   // command word as it stands after this write
   assign next_iac = merge(indirect_access_command, reg_wdata, reg_be);
   // any write to the command register is a command; only a read
   // of the statistics table does anything
   assign cmd_go   = reg_wr && word_addr == ADDR_IAC
                     && next_iac[RDEN_BIT]
                     && next_iac[TSEL_HI:TSEL_LO] == TSEL_STAT;
   assign cmd_addr = next_iac[4:0];
   assign sel_val  = stat_cnt[cmd_addr];

   // -----------------------------------------------------------------
   // writable registers
   // -----------------------------------------------------------------
   // watermark; reserved upper nibble is never stored
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_overrun_watermark <= WM_RST;
      end else if (reg_wr && word_addr == ADDR_WM) begin
         rx_overrun_watermark <= 12'(merge({4'h0, rx_overrun_watermark}, reg_wdata, reg_be));
      end
   end

   // id reserved bit and global control
   always_ff @(posedge clk) begin
      if (rst) begin
         cid_rsv             <= 1'b0;
         global_chip_control <= GCC_RST;
      end else if (reg_wr) begin
         if (word_addr == ADDR_CID && reg_be[0]) begin
            cid_rsv <= reg_wdata[0];
         end
         if (word_addr == ADDR_GCC) begin
            global_chip_control <= merge(global_chip_control, reg_wdata, reg_be);
         end
      end
   end

   // indirect command register holds whatever software last wrote
   always_ff @(posedge clk) begin
      if (rst) begin
         indirect_access_command <= 16'h0000;
      end else if (reg_wr && word_addr == ADDR_IAC) begin
         indirect_access_command <= next_iac;
      end
   end

   // data words: a counter read overrides a software write in the
   // same cycle, since they cannot both hit one address at once
   always_ff @(posedge clk) begin
      if (rst) begin
         indirect_data_low_word  <= 16'h0000;
         indirect_data_high_word <= 16'h0000;
      end else if (cmd_go) begin
         indirect_data_low_word  <= sel_val[15:0];
         indirect_data_high_word <= sel_val[31:16];
      end else if (reg_wr) begin
         if (word_addr == ADDR_IDL) begin
            indirect_data_low_word <= merge(indirect_data_low_word, reg_wdata, reg_be);
         end
         if (word_addr == ADDR_IDH) begin
            indirect_data_high_word <= merge(indirect_data_high_word, reg_wdata, reg_be);
         end
      end
   end

   // power event control; only delay, bit 13 and auto wake live here
   always_ff @(posedge clk) begin
      if (rst) begin
         power_event_control <= 3'h0;
      end else if (reg_wr && word_addr == ADDR_PEC) begin
         if (reg_be[1]) begin
            power_event_control[2:1] <= {reg_wdata[PEC_DLY_BIT], reg_wdata[PEC_R13_BIT]};
         end
         if (reg_be[0]) begin
            power_event_control[0] <= reg_wdata[PEC_AWK_BIT];
         end
      end
   end

   // -----------------------------------------------------------------
   // statistics counters
   // -----------------------------------------------------------------
   // clear-on-read; an event landing on the read cycle is kept as 1
   // so no count is lost between the snapshot and the clear
   for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
      always_ff @(posedge clk) begin
         if (rst) begin
            stat_cnt[i] <= 32'h0000_0000;
         end else if (cmd_go && cmd_addr == 5'(i)) begin
            stat_cnt[i] <= {31'h0000_0000, stat_inc[i]};
         end else if (stat_inc[i]) begin
            stat_cnt[i] <= stat_cnt[i] + 32'h0000_0001;
         end
      end
   end

   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------
   // read data registered, valid one cycle after the strobe;
   // holes and unmapped offsets read zero and ignore writes
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata  <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            unique case (word_addr)
               ADDR_WM:  reg_rdata <= {4'h0, rx_overrun_watermark};
               ADDR_CID: reg_rdata <= cid_word;
               ADDR_GCC: reg_rdata <= global_chip_control;
               ADDR_IAC: reg_rdata <= indirect_access_command;
               ADDR_IDL: reg_rdata <= indirect_data_low_word;
               ADDR_IDH: reg_rdata <= indirect_data_high_word;
               ADDR_PEC: reg_rdata <= {1'b0, power_event_control[2:1], 5'h00,
                                       power_event_control[0], 7'h00};
               default:  reg_rdata <= 16'h0000;
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // indicators and power event
   // -----------------------------------------------------------------
   // indicator drive follows the mode select
   always_ff @(posedge clk) begin
      if (rst) begin
         indicator_first  <= 1'b0;
         indicator_second <= 1'b0;
      end else if (led_mode_select) begin
         indicator_second <= activity;
         indicator_first  <= link_up;
      end else begin
         indicator_second <= speed100;
         indicator_first  <= link_up && activity;
      end
   end

   // delay counts only with auto wake enabled
   assign dly_active = power_event_control[2] && power_event_control[0];

   // power event output, active high
   always_ff @(posedge clk) begin
      if (rst) begin
         power_event_output <= 1'b0;
      end else begin
         power_event_output <= wake_event && (!dly_active || clocks_ready);
      end
   end

   // return to normal power once energy has persisted long enough
   always_ff @(posedge clk) begin
      if (rst) begin
         wake_to_normal <= 1'b0;
      end else begin
         wake_to_normal <= power_event_control[0] && energy_mode
                           && low_power && energy_persisted;
      end
   end

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   sequence s_cmd;
      cmd_go;
   endsequence

   // the snapshot is taken on the command edge, so compare against the
   // selected value one cycle back, not the value standing afterwards
   sequence s_loaded(logic [31:0] v);
      ##1 {indirect_data_high_word, indirect_data_low_word} == $past(v);
   endsequence

   id_read_a: assert property (@(posedge clk) disable iff (rst)
      reg_rd && word_addr == ADDR_CID |=> reg_rdata[15:1] == {ID_FAM, ID_CHIP, ID_REV})
      else $error("id field mismatch");

   wm_read_a: assert property (@(posedge clk) disable iff (rst)
      reg_rd && word_addr == ADDR_WM |=> reg_rdata[15:12] == 4'h0)
      else $error("watermark reserved bits set");

   led_mode_a: assert property (@(posedge clk) disable iff (rst)
      !led_mode_select && $stable(led_mode_select) |=> indicator_second == $past(speed100))
      else $error("indicator mode wrong");

   cmd_load_a: assert property (@(posedge clk) disable iff (rst)
      s_cmd |-> s_loaded(sel_val))
      else $error("counter not loaded");

   cnt_clear_a: assert property (@(posedge clk) disable iff (rst)
      s_cmd |=> stat_cnt[$past(cmd_addr)] <= 32'h0000_0001)
      else $error("counter not cleared");

   no_op_a: assert property (@(posedge clk) disable iff (rst)
      reg_wr && word_addr == ADDR_IAC && !next_iac[RDEN_BIT]
      |=> $stable(indirect_data_low_word) && $stable(indirect_data_high_word))
      else $error("command without read enable acted");

   pme_hold_a: assert property (@(posedge clk) disable iff (rst)
      dly_active && !clocks_ready |=> !power_event_output)
      else $error("power event not held off");

   pme_direct_a: assert property (@(posedge clk) disable iff (rst)
      !power_event_control[0] && wake_event |=> power_event_output)
      else $error("delay applied without auto wake");

   rsvd_read_a: assert property (@(posedge clk) disable iff (rst)
      reg_rd && ((word_addr >= RSV0_LO && word_addr <= RSV0_HI) ||
                 (word_addr >= RSV1_LO && word_addr <= RSV1_HI) ||
                 (word_addr >= RSV2_LO && word_addr <= RSV2_HI)) |=> reg_rdata == 16'h0000)
      else $error("reserved offset not zero");

   wake_a: assert property (@(posedge clk) disable iff (rst)
      !power_event_control[0] |=> !wake_to_normal)
      else $error("wake without auto wake enable");

endmodule

// ==== rtl/mcr_pkg.sv ====
// register map, field layout and reset values of the misc register bank
// assumes a 16-bit register port with byte address and two byte enables
package mcr_pkg;

   // -----------------------------------------------------------------
   // register offsets (byte addresses, word aligned)
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_WM  = 8'hB4;
   localparam logic [7:0] ADDR_CID = 8'hC0;
   localparam logic [7:0] ADDR_GCC = 8'hC6;
   localparam logic [7:0] ADDR_IAC = 8'hC8;
   localparam logic [7:0] ADDR_IDL = 8'hD0;
   localparam logic [7:0] ADDR_IDH = 8'hD2;
   localparam logic [7:0] ADDR_PEC = 8'hD4;

   // reserved holes, no function behind them
   localparam logic [7:0] RSV0_LO = 8'hB6;
   localparam logic [7:0] RSV0_HI = 8'hBF;
   localparam logic [7:0] RSV1_LO = 8'hC2;
   localparam logic [7:0] RSV1_HI = 8'hC5;
   localparam logic [7:0] RSV2_LO = 8'hCA;
   localparam logic [7:0] RSV2_HI = 8'hCF;

   // -----------------------------------------------------------------
   // reset values and identification (id values are arbitrary)
   // -----------------------------------------------------------------
   localparam logic [11:0] WM_RST   = 12'h040;
   localparam logic [15:0] GCC_RST  = 16'h0835;
   localparam logic [7:0]  ID_FAM   = 8'h5A;
   localparam logic [3:0]  ID_CHIP  = 4'h3;
   localparam logic [2:0]  ID_REV   = 3'h2;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int          LED_SEL_BIT = 9;
   localparam int          RDEN_BIT    = 12;
   localparam int          TSEL_HI     = 11;
   localparam int          TSEL_LO     = 10;
   localparam logic [1:0]  TSEL_STAT   = 2'h3;
   localparam int          PEC_DLY_BIT = 14;
   localparam int          PEC_R13_BIT = 13;
   localparam int          PEC_AWK_BIT = 7;
   localparam int          NUM_CNT     = 32;

endpackage

// ==== tb/mcr_host.sv ====
// host model: register reads and writes on the misc bank's port
// assumes clk at 20 MHz; strobes launched on the falling edge
`timescale 1ns/1ns
module mcr_host
   import mcr_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // register port
   output logic      [7:0]  reg_addr,
   output logic      [1:0]  reg_be,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic      [15:0] reg_wdata,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_rvalid
);
   // idle bus at time zero
   initial begin
      reg_addr  = 8'h00;
      reg_be    = 2'h0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 16'h0000;
   end

   // one write strobe across exactly one rising edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      reg_addr  = a;
      reg_be    = 2'h3;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge clk);
      reg_wr    = 1'b0;
      // released lines must not keep the last value
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask

   // read strobe, then a bounded wait for the answer
   task automatic rd(input logic [7:0] a, output logic [15:0] d, output bit ok);
      int n;
      @(negedge clk);
      reg_addr = a;
      reg_be   = 2'h3;
      reg_rd   = 1'b1;
      @(negedge clk);
      reg_rd   = 1'b0;
      reg_addr = ~a;
      n = 0;
      while (reg_rvalid !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      ok = (reg_rvalid === 1'b1);
      d  = reg_rdata;
   endtask

   // counter read: command with table select 11, then both data words
   task automatic cnt(input logic [4:0] idx, output logic [15:0] lo, output logic [15:0] hi, output bit ok);
      bit ok2;
      wr(ADDR_IAC, {3'h0, 1'b1, TSEL_STAT, 5'h00, idx});
      rd(ADDR_IDL, lo, ok);
      rd(ADDR_IDH, hi, ok2);
      ok = ok & ok2;
   endtask
endmodule

// ==== tb/mcr_bank_tb.sv ====
// testbench of the misc register bank, driven through the host model
// assumes mcr_bank and mcr_host are compiled with mcr_pkg
`timescale 1ns/1ns
module mcr_bank_tb
   import mcr_pkg::*;
   ;
   // -----------------------------------------------------------------
   // signals
   // -----------------------------------------------------------------
   logic        clk, rst, reg_wr, reg_rd, reg_rvalid;
   logic [7:0]  reg_addr;
   logic [1:0]  reg_be;
   logic [15:0] reg_wdata, reg_rdata, lo, hi;
   logic [31:0] stat_inc;
   logic        link_up, speed100, activity, indicator_first, indicator_second;
   logic        wake_event, clocks_ready, energy_mode, low_power, energy_persisted;
   logic        power_event_output, wake_to_normal;
   logic [11:0] watermark_config_field;
   int          fail_count, samples_checked;
   bit          ok;
   logic [7:0]  rsv [6] = '{8'hB6, 8'hBE, 8'hC2, 8'hC4, 8'hCA, 8'hCE};

   mcr_bank uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_be(reg_be), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .stat_inc(stat_inc), .link_up(link_up), .speed100(speed100), .activity(activity),
      .indicator_first(indicator_first), .indicator_second(indicator_second),
      .wake_event(wake_event), .clocks_ready(clocks_ready), .energy_mode(energy_mode),
      .low_power(low_power), .energy_persisted(energy_persisted),
      .power_event_output(power_event_output), .wake_to_normal(wake_to_normal),
      .watermark_config_field(watermark_config_field));

   mcr_host host (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_be(reg_be), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   // 50 ns clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic end_of_test;
      if (fail_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // a missing read answer counts as a mismatch and ends the run
   task automatic gate(input bit k);
      if (!k) begin
         fail_count++;
         $display("CHECK FAILED at %0t: no read answer", $time);
         end_of_test();
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] d;
      host.rd(a, d, ok);
      gate(ok);
      check(d, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      fail_count = 0;
      samples_checked = 0;
      rst = 1'b1;
      stat_inc = 32'h0000_0000;
      {link_up, speed100, activity, wake_event, clocks_ready} = 5'h00;
      {energy_mode, low_power, energy_persisted} = 3'h0;
      cyc(4);
      rst = 1'b0;
      // reset values
      rchk(ADDR_WM, 16'h0040);
      check(16'(watermark_config_field), 16'h0040);
      rchk(ADDR_CID, {ID_FAM, ID_CHIP, ID_REV, 1'b0});
      rchk(ADDR_GCC, 16'h0835);
      rchk(ADDR_IDL, 16'h0000);
      rchk(ADDR_IDH, 16'h0000);
      // reserved watermark bits, read-only id fields and writable id bit 0
      host.wr(ADDR_WM, 16'hFFFF);
      host.wr(ADDR_CID, 16'hFFFF);
      rchk(ADDR_WM, 16'h0FFF);
      check(16'(watermark_config_field), 16'h0FFF);
      rchk(ADDR_CID, {ID_FAM, ID_CHIP, ID_REV, 1'b1});
      // reserved holes store nothing and disturb nothing
      foreach (rsv[k]) begin
         host.wr(rsv[k], 16'hFFFF);
         rchk(rsv[k], 16'h0000);
      end
      rchk(ADDR_WM, 16'h0FFF);
      // indicator modes, both settings of the select bit
      {link_up, speed100, activity} = 3'b110;
      cyc(2);
      check(16'({indicator_second, indicator_first}), 16'h0002);
      {link_up, speed100, activity} = 3'b101;
      cyc(2);
      check(16'({indicator_second, indicator_first}), 16'h0001);
      host.wr(ADDR_GCC, 16'h0A35);
      {link_up, speed100, activity} = 3'b110;
      cyc(2);
      check(16'({indicator_second, indicator_first}), 16'h0001);
      {link_up, speed100, activity} = 3'b001;
      cyc(2);
      check(16'({indicator_second, indicator_first}), 16'h0002);
      rchk(ADDR_GCC, 16'h0A35);
      // counter i ends at 0x0001_0001 + i, so the high word is exercised
      stat_inc = 32'hFFFF_FFFF;
      cyc(65537);
      for (int c = 0; c < 31; c++) begin
         stat_inc = 32'hFFFF_FFFF << (c + 1);
         cyc(1);
      end
      stat_inc = 32'h0000_0000;
      for (int i = 0; i < 32; i++) begin
         host.cnt(5'(i), lo, hi, ok);
         gate(ok);
         check(lo, 16'(i + 1));
         check(hi, 16'h0001);
      end
      // commands that must leave the data words alone
      host.wr(ADDR_IAC, 16'h0C00);
      rchk(ADDR_IDL, 16'h0020);
      host.wr(ADDR_IAC, 16'h1800);
      rchk(ADDR_IDL, 16'h0020);
      // second read of the same counter finds it cleared
      host.cnt(5'h00, lo, hi, ok);
      gate(ok);
      check(lo, 16'h0000);
      check(hi, 16'h0000);
      rchk(ADDR_IAC, 16'h1C00);
      host.wr(ADDR_IDH, 16'hBEEF);
      rchk(ADDR_IDH, 16'hBEEF);
      // power event delay, only with auto wake-up set
      host.wr(ADDR_PEC, 16'hFFFF);
      rchk(ADDR_PEC, 16'h6080);
      wake_event = 1'b1;
      cyc(2);
      check(16'(power_event_output), 16'h0000);
      clocks_ready = 1'b1;
      cyc(2);
      check(16'(power_event_output), 16'h0001);
      clocks_ready = 1'b0;
      host.wr(ADDR_PEC, 16'h0080);
      cyc(1);
      check(16'(power_event_output), 16'h0001);
      host.wr(ADDR_PEC, 16'h4000);
      cyc(1);
      check(16'(power_event_output), 16'h0001);
      wake_event = 1'b0;
      cyc(2);
      check(16'(power_event_output), 16'h0000);
      // auto wake-up to normal power
      {energy_mode, low_power, energy_persisted} = 3'h7;
      cyc(2);
      check(16'(wake_to_normal), 16'h0000);
      host.wr(ADDR_PEC, 16'h0080);
      cyc(1);
      check(16'(wake_to_normal), 16'h0001);
      energy_persisted = 1'b0;
      cyc(2);
      check(16'(wake_to_normal), 16'h0000);
      end_of_test();
   end
endmodule
